/* File: sram_pkg.sv */
// package: timing constants and state encoding for the async sram host controller
// assumes: 100 mhz system clock; timing figures are for the slowest supported speed grade
package sram_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // memory timing in ns (slowest grade, safe for all)
  localparam int READ_CYCLE_NS      = 15;  // read cycle / address access
  localparam int WRITE_PULSE_NS     = 10;  // plain minimum write pulse
  localparam int WRITE_TO_HIGHZ_NS  = 5;   // strobe low to outputs released
  localparam int DATA_SETUP_NS      = 7;   // data_setup_to_write_end
  localparam int SELECT_TO_END_NS   = 10;  // select to end of write
  localparam int OUT_DISABLE_NS     = 5;   // output gate high to outputs released

  // least times round up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_CYC          = cyc_up(READ_CYCLE_NS);
  localparam int WPULSE_PLAIN_CYC  = cyc_up(WRITE_PULSE_NS);
  localparam int WPULSE_GATED_CYC  = cyc_up(WRITE_TO_HIGHZ_NS + DATA_SETUP_NS);
  localparam int DSETUP_CYC        = cyc_up(DATA_SETUP_NS);
  localparam int SELECT_END_CYC    = cyc_up(SELECT_TO_END_NS);
  localparam int RELEASE_CYC       = cyc_up(OUT_DISABLE_NS);

  localparam logic [3:0] CNT_RESET = 4'h0;

  // gray-coded states along idle -> setup -> strobe -> finish
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_FINISH = 3'b010,
    ST_READ   = 3'b110
  } host_state_e;

endpackage

/* File: pin_sync.sv */
// two-flop synchroniser for a bus of pin inputs
// assumes: inputs are asynchronous to sys_clk_in
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

/* File: sram_host.sv */
// host controller driving an asynchronous byte-wide static ram over its pins
// assumes: one request at a time on the user side; ram data pins join via the bench
// ----------------------------------------------------------------------------

//
// Operation
// RULE_01 - write strobe high throughout every read
// RULE_02 - address valid before chip select falls
// RULE_03 - ram writes only during select-strobe overlap
// RULE_04 - gated write: strobe covers release plus setup
// RULE_05 - gate high: plain minimum strobe width
// RULE_06 - never drive data while ram drives
// RULE_07 - late select keeps ram outputs off
// RULE_08 - select held through select-to-end time
// RULE_09 - ram drives only on select, gate, no strobe
// RULE_10 - selected ram outputs follow address
module sram_host #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 8
) (
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic              req_gate_low_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic      [DATA_W-1:0] rsp_rdata_out,
  output logic      [ADDR_W-1:0] mem_addr_out,
  output logic                   chip_select_n_out,
  output logic                   output_gate_n_out,
  output logic                   write_strobe_n_out,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic      [DATA_W-1:0] mem_data_out,
  output logic                   mem_data_oe_n_out
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  sram_pkg::host_state_e state_reg, state_next;
  logic [3:0]        cnt_reg, cnt_next;
  logic              wr_reg, wr_next;
  logic              gate_reg, gate_next;
  logic              ready_reg, ready_next;
  logic              rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic              cs_n_reg, cs_n_next;
  logic              oe_n_reg, oe_n_next;
  logic              we_n_reg, we_n_next;
  logic              doe_n_reg, doe_n_next;
  logic [DATA_W-1:0] data_sync;

  // read data comes from the pins, so it is synchronised before capture
  pin_sync #(.WIDTH(DATA_W)) u_data_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   (mem_data_in),
    .sync_out   (data_sync)
  );

  localparam logic [3:0] READ_WAIT = 4'(sram_pkg::READ_CYC + 2); // plus synchroniser

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  // strobe width depends on whether the gate stays low during the write
  function automatic logic [3:0] strobe_len(input logic gate_low);
    int n;
    n = gate_low ? sram_pkg::WPULSE_GATED_CYC : sram_pkg::WPULSE_PLAIN_CYC; // [RULE_04] [RULE_05]
    if (n < sram_pkg::SELECT_END_CYC) n = sram_pkg::SELECT_END_CYC;        // [RULE_08]
    return 4'(n);
  endfunction

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    wr_next     = wr_reg;
    gate_next   = gate_reg;
    ready_next  = ready_reg;
    rvalid_next = 1'b0;
    rdata_next  = rdata_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    cs_n_next   = cs_n_reg;
    oe_n_next   = oe_n_reg;
    we_n_next   = we_n_reg;
    doe_n_next  = doe_n_reg;
    case (state_reg)
      sram_pkg::ST_IDLE: begin
        ready_next = 1'b1;
        if (req_valid_in && ready_reg) begin
          ready_next = 1'b0;
          addr_next  = req_addr_in;                  // address leads select [RULE_02]
          wdata_next = req_wdata_in;
          wr_next    = req_write_in;
          gate_next  = req_gate_low_in;
          cnt_next   = sram_pkg::CNT_RESET;
          state_next = sram_pkg::ST_SETUP;
        end
      end
      sram_pkg::ST_SETUP: begin
        // select falls one cycle after the address settles [RULE_02]
        cs_n_next = 1'b0;
        cnt_next  = sram_pkg::CNT_RESET;
        if (wr_reg) begin
          oe_n_next  = ~gate_reg;
          we_n_next  = 1'b0;                         // strobe falls with select [RULE_07]
          doe_n_next = ~(~gate_reg);                 // gate high: drive at once [RULE_06]
          state_next = sram_pkg::ST_STROBE;
        end else begin
          oe_n_next  = 1'b0;
          we_n_next  = 1'b1;                         // [RULE_01]
          doe_n_next = 1'b1;                         // ram owns the bus [RULE_09]
          state_next = sram_pkg::ST_READ;
        end
      end
      sram_pkg::ST_STROBE: begin
        cnt_next = cnt_reg + 4'h1;
        // gated write waits for ram release before driving [RULE_04] [RULE_06]
        if (gate_reg && cnt_reg == 4'(sram_pkg::RELEASE_CYC - 1)) begin
          doe_n_next = 1'b0;
        end
        if (cnt_reg == strobe_len(gate_reg) - 4'h1) begin
          we_n_next  = 1'b1;                         // write ends by strobe [RULE_03]
          cs_n_next  = 1'b1;
          oe_n_next  = 1'b1;
          state_next = sram_pkg::ST_FINISH;
        end
      end
      sram_pkg::ST_READ: begin
        cnt_next = cnt_reg + 4'h1;
        // data follows address and is sampled after access time [RULE_10]
        if (cnt_reg == READ_WAIT - 4'h1) begin
          rdata_next  = data_sync;
          rvalid_next = 1'b1;
          cs_n_next   = 1'b1;
          oe_n_next   = 1'b1;
          state_next  = sram_pkg::ST_FINISH;
        end
      end
      sram_pkg::ST_FINISH: begin
        // hold data one cycle past strobe rise, then release the bus
        doe_n_next = 1'b1;
        ready_next = 1'b1;
        state_next = sram_pkg::ST_IDLE;
      end
      default: begin
        state_next = sram_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_reg  <= sram_pkg::ST_IDLE;
      cnt_reg    <= sram_pkg::CNT_RESET;
      wr_reg     <= 1'b0;
      gate_reg   <= 1'b0;
      ready_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      cs_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      doe_n_reg  <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      wr_reg     <= wr_next;
      gate_reg   <= gate_next;
      ready_reg  <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      cs_n_reg   <= cs_n_next;
      oe_n_reg   <= oe_n_next;
      we_n_reg   <= we_n_next;
      doe_n_reg  <= doe_n_next;
    end
  end

  // outputs straight from flops
  assign req_ready_out      = ready_reg;
  assign rsp_valid_out      = rvalid_reg;
  assign rsp_rdata_out      = rdata_reg;
  assign mem_addr_out       = addr_reg;
  assign chip_select_n_out  = cs_n_reg;
  assign output_gate_n_out  = oe_n_reg;
  assign write_strobe_n_out = we_n_reg;
  assign mem_data_out       = wdata_reg;
  assign mem_data_oe_n_out  = doe_n_reg;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_read_no_strobe: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_01]
    (state_reg == sram_pkg::ST_READ) |-> write_strobe_n_out)
    else $error("write strobe low during read");

  a_addr_stable: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_02]
    (!chip_select_n_out && $past(!chip_select_n_out)) |-> $stable(mem_addr_out))
    else $error("address moved while selected");

  a_overlap_write: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_03]
    $fell(write_strobe_n_out) |-> !chip_select_n_out)
    else $error("strobe fell without select");

  a_gated_width: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_04]
    ($fell(write_strobe_n_out) && !output_gate_n_out)
      |-> !write_strobe_n_out[*2])
    else $error("gated write pulse too short");

  a_plain_width: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_05]
    ($fell(write_strobe_n_out) && output_gate_n_out) |=> write_strobe_n_out)
    else $error("plain write pulse wrong length");

  a_no_contention: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_06]
    !mem_data_oe_n_out |-> (output_gate_n_out || !write_strobe_n_out
                            && $past(!write_strobe_n_out)))
    else $error("host drives data while ram may drive");

  a_late_select: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_07]
    $fell(chip_select_n_out) && state_reg == sram_pkg::ST_STROBE
      |-> !write_strobe_n_out)
    else $error("select fell before strobe on write");

  a_select_held: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_08]
    $rose(write_strobe_n_out) |-> $past(!chip_select_n_out))
    else $error("select released before write end");

  a_read_gated: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_09]
    (state_reg == sram_pkg::ST_READ) |-> mem_data_oe_n_out && !output_gate_n_out)
    else $error("read without gate or with host drive");

  a_read_answer: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_10]
    $rose(rsp_valid_out) |-> $past(state_reg == sram_pkg::ST_READ))
    else $error("read answer out of sequence");

endmodule

/* File: sram_model.sv */
// behavioural model of the byte-wide asynchronous static ram on the host's pins
// assumes: host data joins the shared wire here; viol_out counts host timing faults
module sram_model #(
  parameter int ACC_NS = 15
) (
  input  wire logic [16:0] addr_in,
  input  wire logic        cs_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [7:0]  host_data_in,
  input  wire logic        host_oe_n_in,
  output logic      [7:0]  bus_out,
  output int               viol_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071];
  logic       rd_ok;
  logic       gate_lo;
  int         stamp;
  realtime    t_we;
  realtime    t_cs;
  wire        ram_drv = !cs_n_in && !oe_n_in && we_n_in;
  initial begin
    rd_ok = 1'b0;
    stamp = 0;
    viol_out = 0;
    gate_lo = 1'b0;
    // far in the past, so the first rise out of reset is not taken for a short pulse
    t_we = -1.0e6;
    t_cs = -1.0e6;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // any address, select, gate or strobe change restarts the access time, so slow data is modelled
  always @(addr_in or cs_n_in or oe_n_in or we_n_in) begin
    stamp++;
    rd_ok = 1'b0;
    fork
      begin
        automatic int s = stamp;
        #(ACC_NS);
        if (s == stamp) rd_ok = 1'b1;
      end
    join_none
  end
  // write happens only in the select and strobe overlap
  always @* if (!cs_n_in && !we_n_in && !host_oe_n_in) mem[addr_in] = host_data_in;
  // undriven or not yet valid: inverse, so a stale sample never matches
  assign bus_out = !host_oe_n_in ? host_data_in :
                   (ram_drv && rd_ok) ? mem[addr_in] : ~mem[addr_in];
  // ------------------------------------------------------------------
  // host timing checks
  // ------------------------------------------------------------------
  always @(negedge cs_n_in) t_cs = $realtime;
  always @(negedge we_n_in) begin
    t_we = $realtime;
    #1 gate_lo = !oe_n_in;
  end
  always @(posedge we_n_in) if ($realtime - t_we < (gate_lo ? 12 : 10)) viol_out++;
  always @(posedge cs_n_in) if ($realtime - t_cs < 10) viol_out++;
  // pins that switch on one edge settle first, so a zero-width overlap is not counted
  always @(host_oe_n_in or ram_drv) #0.1 if (!host_oe_n_in && ram_drv) viol_out++;
endmodule

/* File: test_async_sram_access_cycles.sv */
// self-checking bench for the static ram host controller
// assumes: ram model on the far side; fixed-seed random reads and writes
module test_async_sram_access_cycles;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 0, srst_in = 1, req_valid_in = 0, req_write_in = 0, req_gate_low_in = 0;
  logic [16:0] req_addr_in = 17'h0_0000, mem_addr_out;
  logic [7:0]  req_wdata_in = 8'h00, rsp_rdata_out, mem_data_in, mem_data_out;
  logic req_ready_out, rsp_valid_out, chip_select_n_out, output_gate_n_out;
  logic write_strobe_n_out, mem_data_oe_n_out;
  int err_count = 0, checks_done = 0, viol;
  logic [31:0] rng = 32'ha73205ed;
  logic [7:0]  shadow [int];
  bit prev_wr = 0;
  // read answer seen at this negedge: access cycles, two sync flops, launch and capture
  localparam int RD_K = sram_pkg::READ_CYC + 4;
  always #5 sys_clk_in = ~sys_clk_in;
  sram_host dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_gate_low_in(req_gate_low_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .mem_addr_out(mem_addr_out),
    .chip_select_n_out(chip_select_n_out), .output_gate_n_out(output_gate_n_out),
    .write_strobe_n_out(write_strobe_n_out), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe_n_out(mem_data_oe_n_out));
  sram_model ram (.addr_in(mem_addr_out), .cs_n_in(chip_select_n_out),
    .oe_n_in(output_gate_n_out), .we_n_in(write_strobe_n_out), .host_data_in(mem_data_out),
    .host_oe_n_in(mem_data_oe_n_out), .bus_out(mem_data_in), .viol_out(viol));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // strobe and select cycles of a write: pulse for the gate mode, never below select-to-end
  function automatic int exp_strobe(input bit gate);
    int n;
    n = gate ? sram_pkg::WPULSE_GATED_CYC : sram_pkg::WPULSE_PLAIN_CYC;
    return (n < sram_pkg::SELECT_END_CYC) ? sram_pkg::SELECT_END_CYC : n;
  endfunction
  function automatic logic [7:0] expect_rd(input logic [16:0] a);
    return shadow.exists(int'(a)) ? shadow[int'(a)] : 8'h00;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access; valid rises early, and after a write the request must be taken on the first edge
  task automatic issue(input bit wr, input bit gate, input logic [16:0] a, input logic [7:0] d);
    int n;
    int we_lo;
    int cs_lo;
    n = 0;
    we_lo = 0;
    cs_lo = 0;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_gate_low_in <= gate;
    req_addr_in <= a;
    req_wdata_in <= d;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 20);
    if (prev_wr) chk("take wait", 32'd1, 32'(n));
    req_valid_in <= 1'b0;
    // a write window runs one negedge past the strobe rise, so counts are exact
    for (int k = 1; k <= (wr ? exp_strobe(gate) + 2 : 7); k++) begin
      @(negedge sys_clk_in);
      if (chip_select_n_out === 1'b0) begin
        chk("addr at select", 32'(a), 32'(mem_addr_out));
        cs_lo++;
      end
      if (write_strobe_n_out === 1'b0) we_lo++;
      if (!wr) chk("strobe in read", 32'd1, 32'(write_strobe_n_out));
      if (!wr) chk("rsp valid", 32'(k == RD_K), 32'(rsp_valid_out));
      if (wr && k == 2) chk("gate", 32'(!gate), 32'(output_gate_n_out));
      if (wr && k == 2 && gate) chk("host drive", 32'd1, 32'(mem_data_oe_n_out));
    end
    if (wr) begin
      chk("strobe cycles", 32'(exp_strobe(gate)), 32'(we_lo));
      chk("select cycles", 32'(exp_strobe(gate)), 32'(cs_lo));
      shadow[int'(a)] = d;
    end else begin
      chk("read data", 32'(expect_rd(a)), 32'(rsp_rdata_out));
    end
    prev_wr = wr;
  endtask
  task automatic finish_test();
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    #200000;
    err_count++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    logic [31:0] r;
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    // corners: both ends of the address space, both write modes, read right after write
    issue(1, 0, 17'h0_0000, 8'ha5);
    issue(1, 1, 17'h1_ffff, 8'h3c);
    issue(0, 0, 17'h0_0000, 8'h00);
    issue(0, 0, 17'h1_ffff, 8'h00);
    issue(0, 0, 17'h0_1234, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 60; i++) begin
      r = xs();
      issue(r[0], r[1], {r[2], r[31:16]} & 17'h0_003f, r[15:8]);
    end
    $display("test random done");
    chk("ram timing faults", 32'd0, 32'(viol));
    finish_test();
  end
endmodule
